// ===== design/rcrf_dev.sv
// device end: parses requests, drives the radio, frames responses
// Notes on behaviour
// - frame opens with one delimiter byte
// - two length bytes count type to data
// - type byte 17 marks configuration request
// - answer carries type code 97
// - zero correlation id suppresses the answer
// - answer echoes the request's correlation id
// - host puts destination address at five
// - short addressing uses all-ones destination
// - host fills reserved field with FFFE
// - option bit zero disables link acks
// - option bit one applies change now
// - host clears unused option bits
// - option bit four needs secure session
// - two ASCII bytes name the parameter
// - value present means write, absent read
// - read answer returns current parameter value
// - checksum is FF minus byte sum
// - host never broadcasts configuration requests
`timescale 1ns/10ps
`include "rcrf_consts.svh"
module rcrf_dev
  import rcrf_pkg::*;
#(
  parameter int PMAX = 8,
  parameter int PW   = $clog2(PMAX + 1)
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // host link
  rcrf_if.dev                    lnk,
  // request to the remote node
  output logic                   rn_req_valid,
  input  wire logic              rn_req_ready,
  output logic                   rn_write,
  output logic                   rn_no_ack,
  output logic                   rn_apply,
  output logic                   rn_secure,
  output logic [63:0]            rn_dest,
  output logic [15:0]            rn_cmd,
  output logic [8*PMAX-1:0]      rn_param,
  output logic [PW-1:0]          rn_plen,
  // answer from the remote node
  input  wire logic              rn_rsp_valid,
  input  wire logic [7:0]        rn_rsp_status,
  input  wire logic [8*PMAX-1:0] rn_rsp_value,
  input  wire logic [PW-1:0]     rn_rsp_len,
  // session and status
  input  wire logic              secure_ok,
  output logic                   changes_pending,
  output logic                   bad_frame
);
  // ====================================================
  // state
  typedef struct packed {
    rcrf_st_e          st;
    logic              rdy;
    logic              bad;
    logic [15:0]       len;
    logic [15:0]       pos;
    logic [7:0]        sum;
    logic [7:0]        id;
    logic [63:0]       dest;
    logic [7:0]        opts;
    logic [15:0]       cmd;
    logic [8*PMAX-1:0] prm;
    logic [PW-1:0]     plen;
    logic              req;
    logic              wr;
    logic              pend;
    logic [7:0]        rst;
    logic [8*PMAX-1:0] val;
    logic [PW-1:0]     vlen;
  } rcrf_dev_s;
  rcrf_dev_s s_reg, s_next;

  logic        rx;
  logic [7:0]  d;
  logic [15:0] lenv;
  logic [15:0] rlen;
  logic [7:0]  tb;
  logic        buf_rdy;

  // ====================================================
  // response byte generator
  assign rlen = `RCRF_RSP_BASE + 16'(s_reg.vlen);
  always_comb begin
    tb = rcrf_csum(s_reg.sum);
    if (s_reg.pos == 16'h0000)
      tb = `RCRF_SOF;
    else if (s_reg.pos == 16'h0001)
      tb = rlen[15:8];
    else if (s_reg.pos == 16'h0002)
      tb = rlen[7:0];
    else if (s_reg.pos == `RCRF_O_TYPE)
      tb = `RCRF_T_RSP;
    else if (s_reg.pos == `RCRF_O_ID)
      tb = s_reg.id;
    else if (s_reg.pos == `RCRF_R_CMD)
      tb = s_reg.cmd[15:8];
    else if (s_reg.pos == `RCRF_R_CMD + 16'h0001)
      tb = s_reg.cmd[7:0];
    else if (s_reg.pos == `RCRF_R_ST)
      tb = s_reg.rst;
    else if (s_reg.pos < `RCRF_R_VAL + 16'(s_reg.vlen))
      tb = s_reg.val[8*PMAX-1 -: 8];
  end

  // ====================================================
  // frame walker
  assign rx   = lnk.h2d_valid && s_reg.rdy;
  assign d    = lnk.h2d_data;
  assign lenv = {s_reg.len[15:8], d};

  always_comb begin
    s_next     = s_reg;
    s_next.bad = 1'b0;
    unique case (s_reg.st)
      st_hunt: begin
        // embedded 7E bytes are only an issue while hunting
        if (rx && d == `RCRF_SOF) s_next.st = st_len_h;
      end
      st_len_h: begin
        if (rx) begin
          s_next.len[15:8] = d;
          s_next.st        = st_len_l;
        end
      end
      st_len_l: begin
        if (rx) begin
          s_next.len  = lenv;
          s_next.pos  = `RCRF_O_TYPE;
          s_next.sum  = 8'h00;
          s_next.plen = '0;
          s_next.prm  = '0;
          s_next.st   = st_body;
          // lengths outside header plus value room are dropped
          if (lenv < `RCRF_LEN_MIN ||
              lenv > `RCRF_LEN_MIN + 16'(PMAX)) begin
            s_next.st  = st_hunt;
            s_next.bad = 1'b1;
          end
        end
      end
      st_body: begin
        if (rx) begin
          s_next.sum = s_reg.sum + d;
          s_next.pos = s_reg.pos + 16'h0001;
          if (s_reg.pos == `RCRF_O_ID) s_next.id = d;
          if (s_reg.pos >= `RCRF_O_DEST && s_reg.pos < `RCRF_O_RSVD)
            s_next.dest = {s_reg.dest[55:0], d};
          if (s_reg.pos == `RCRF_O_OPT) s_next.opts = d;
          if (s_reg.pos == `RCRF_O_CMD ||
              s_reg.pos == `RCRF_O_CMD + 16'h0001)
            s_next.cmd = {s_reg.cmd[7:0], d};
          if (s_reg.pos >= `RCRF_O_PRM) begin
            s_next.prm  = {s_reg.prm[8*PMAX-9:0], d};
            s_next.plen = s_reg.plen + PW'(1);
          end
          if (s_reg.pos == s_reg.len + `RCRF_O_TYPE - 16'h0001)
            s_next.st = st_csum;
          if (s_reg.pos == `RCRF_O_TYPE && d != `RCRF_T_REQ) begin
            s_next.st  = st_hunt;
            s_next.bad = 1'b1;
          end
        end
      end
      st_csum: begin
        if (rx) begin
          s_next.pos = 16'h0000;
          s_next.sum = 8'h00;
          s_next.wr  = (s_reg.plen != '0);
          if (d != rcrf_csum(s_reg.sum)) begin
            s_next.st  = st_hunt;
            s_next.bad = 1'b1;
          end else if (s_reg.opts[`RCRF_B_SEC] && !secure_ok) begin
            // encrypted request without a session is refused here
            s_next.rst  = `RCRF_ST_SEC;
            s_next.vlen = '0;
            s_next.st   = (s_reg.id == 8'h00) ? st_hunt : st_resp;
          end else begin
            s_next.req = 1'b1;
            s_next.st  = st_req;
            if (s_reg.opts[`RCRF_B_APPLY] ||
                s_reg.cmd == `RCRF_CMD_APPLY)
              s_next.pend = 1'b0;
            else if (s_reg.plen != '0)
              s_next.pend = 1'b1;
          end
        end
      end
      st_req: begin
        if (rn_req_ready) begin
          s_next.req = 1'b0;
          s_next.st  = st_wait;
        end
      end
      st_wait: begin
        if (rn_rsp_valid) begin
          s_next.rst  = rn_rsp_status;
          s_next.vlen = '0;
          if (!s_reg.wr) begin
            // left-align so bytes leave from the top
            s_next.val  = rn_rsp_value <<
                          (8 * (PMAX - int'(rn_rsp_len)));
            s_next.vlen = rn_rsp_len;
          end
          s_next.st = (s_reg.id == 8'h00) ? st_hunt : st_resp;
        end
      end
      st_resp: begin
        if (buf_rdy) begin
          s_next.pos = s_reg.pos + 16'h0001;
          if (s_reg.pos >= `RCRF_O_TYPE) s_next.sum = s_reg.sum + tb;
          if (s_reg.pos >= `RCRF_R_VAL)
            s_next.val = {s_reg.val[8*PMAX-9:0], 8'h00};
          if (s_reg.pos == `RCRF_R_VAL + 16'(s_reg.vlen))
            s_next.st = st_hunt;
        end
      end
    endcase
    // link stalls while the remote node or the answer is busy
    s_next.rdy = (s_next.st == st_hunt) || (s_next.st == st_len_h) ||
                 (s_next.st == st_len_l) || (s_next.st == st_body) ||
                 (s_next.st == st_csum);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) s_reg <= '0;
    else        s_reg <= s_next;
  end

  // ====================================================
  // response path through the two-entry buffer
  rcrf_buf #(.W(8)) u_buf (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .in_data   (tb),
    .in_valid  (s_reg.st == st_resp),
    .in_ready  (buf_rdy),
    .out_data  (lnk.d2h_data),
    .out_valid (lnk.d2h_valid),
    .out_ready (lnk.d2h_ready)
  );

  // ====================================================
  // outputs
  assign lnk.h2d_ready   = s_reg.rdy;
  assign rn_req_valid    = s_reg.req;
  assign rn_write        = s_reg.wr;
  assign rn_no_ack       = s_reg.opts[`RCRF_B_NOACK];
  assign rn_apply        = s_reg.opts[`RCRF_B_APPLY];
  assign rn_secure       = s_reg.opts[`RCRF_B_SEC];
  assign rn_dest         = s_reg.dest;
  assign rn_cmd          = s_reg.cmd;
  assign rn_param        = s_reg.prm;
  assign rn_plen         = s_reg.plen;
  assign changes_pending = s_reg.pend;
  assign bad_frame       = s_reg.bad;
endmodule

// ===== design/rcrf_consts.svh
// constants of the remote configuration request framer
`ifndef RCRF_CONSTS_SVH
`define RCRF_CONSTS_SVH
// ====================================================
// frame bytes
`define RCRF_SOF        8'h7E
`define RCRF_T_REQ      8'h17
`define RCRF_T_RSP      8'h97
`define RCRF_CSUM_BASE  8'hFF
`define RCRF_RSVD       16'hFFFE
`define RCRF_SHORT      64'hFFFF_FFFF_FFFF_FFFF
`define RCRF_BCAST      64'h0000_0000_0000_FFFF
`define RCRF_CMD_APPLY  16'h4143
// ====================================================
// request offsets, counted from the delimiter
`define RCRF_O_TYPE     16'h0003
`define RCRF_O_ID       16'h0004
`define RCRF_O_DEST     16'h0005
`define RCRF_O_RSVD     16'h000D
`define RCRF_O_OPT      16'h000F
`define RCRF_O_CMD      16'h0010
`define RCRF_O_PRM      16'h0012
`define RCRF_LEN_MIN    16'h000F
// ====================================================
// option bits
`define RCRF_B_NOACK    0
`define RCRF_B_APPLY    1
`define RCRF_B_SEC      4
`define RCRF_OPT_MASK   8'h13
// ====================================================
// response layout and status codes
`define RCRF_R_CMD      16'h0005
`define RCRF_R_ST       16'h0007
`define RCRF_R_VAL      16'h0008
`define RCRF_RSP_BASE   16'h0005
`define RCRF_ST_SEC     8'hE0
// ====================================================
// host register map
`define RCRF_A_CTRL     8'h00
`define RCRF_A_STAT     8'h04
`define RCRF_A_ID       8'h08
`define RCRF_A_DLO      8'h0C
`define RCRF_A_DHI      8'h10
`define RCRF_A_OPTCMD   8'h14
`define RCRF_A_PLO      8'h18
`define RCRF_A_PHI      8'h1C
`define RCRF_A_PLEN     8'h20
`define RCRF_A_RLO      8'h24
`define RCRF_A_RHI      8'h28
`define RCRF_C_GO       0
`define RCRF_C_SHORT    1
`endif

// ===== design/rcrf_pkg.sv
// types and helpers shared by both framer ends
package rcrf_pkg;
`include "rcrf_consts.svh"
  // ====================================================
  // frame walker states
  typedef enum logic [2:0] {
    st_hunt, st_len_h, st_len_l, st_body, st_csum,
    st_req, st_wait, st_resp
  } rcrf_st_e;

  // checksum byte from the running sum
  function automatic logic [7:0] rcrf_csum(input logic [7:0] sum);
    return `RCRF_CSUM_BASE - sum;
  endfunction
endpackage

// ===== design/rcrf_if.sv
// byte link between host controller and device
`timescale 1ns/10ps
interface rcrf_if;
  logic [7:0] h2d_data;
  logic       h2d_valid;
  logic       h2d_ready;
  logic [7:0] d2h_data;
  logic       d2h_valid;
  logic       d2h_ready;
  modport dev  (input h2d_data, h2d_valid, d2h_ready,
                output h2d_ready, d2h_data, d2h_valid);
  modport host (output h2d_data, h2d_valid, d2h_ready,
                input h2d_ready, d2h_data, d2h_valid);
endinterface

// ===== design/rcrf_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module rcrf_buf #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_b,
  // filling side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // draining side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  typedef struct packed {
    logic [W-1:0] md;
    logic         mv;
    logic [W-1:0] sd;
    logic         sv;
  } rcrf_buf_s;
  rcrf_buf_s s_reg, s_next;

  // spare entry catches the word that arrives while the head stalls
  always_comb begin
    s_next = s_reg;
    if (s_reg.mv && out_ready) s_next.mv = 1'b0;
    if (!s_next.mv && s_reg.sv) begin
      s_next.md = s_reg.sd;
      s_next.mv = 1'b1;
      s_next.sv = 1'b0;
    end
    if (in_valid && !s_reg.sv) begin
      if (!s_next.mv) begin
        s_next.md = in_data;
        s_next.mv = 1'b1;
      end else begin
        s_next.sd = in_data;
        s_next.sv = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) s_reg <= '0;
    else        s_reg <= s_next;
  end

  assign in_ready  = !s_reg.sv;
  assign out_data  = s_reg.md;
  assign out_valid = s_reg.mv;
endmodule

// ===== design/rcrf_host.sv
// host end: APB registers, request framing, response parsing
`timescale 1ns/10ps
`include "rcrf_consts.svh"
module rcrf_host
  import rcrf_pkg::*;
#(
  parameter int PMAX = 8,
  parameter int PW   = $clog2(PMAX + 1)
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // device link
  rcrf_if.host             lnk
);
  typedef struct packed {
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              busy;
    logic              done;
    logic              refused;
    logic              short_a;
    logic [7:0]        id;
    logic [63:0]       dest;
    logic [7:0]        opts;
    logic [15:0]       cmd;
    logic [63:0]       prm;
    logic [PW-1:0]     plen;
    logic              txr;
    logic              tv;
    logic [7:0]        td;
    logic [15:0]       k;
    logic [7:0]        ts;
    logic [63:0]       sd;
    logic [8*PMAX-1:0] sp;
    rcrf_st_e          rs;
    logic              rrdy;
    logic [15:0]       len;
    logic [15:0]       pos;
    logic [7:0]        sum;
    logic              idok;
    logic [7:0]        rst;
    logic [63:0]       rval;
    logic [3:0]        rvlen;
  } rcrf_host_s;
  rcrf_host_s s_reg, s_next;

  logic        rsel;
  logic        wr;
  logic        hit;
  logic [31:0] rdv;
  logic [7:0]  b;
  logic [15:0] tlen;
  logic        rx;
  logic [7:0]  d;

  // ====================================================
  // register read decode
  always_comb begin
    hit = 1'b1;
    rdv = 32'h0000_0000;
    unique case (paddr)
      `RCRF_A_CTRL:   rdv = {31'h0, s_reg.short_a} << `RCRF_C_SHORT;
      `RCRF_A_STAT:   rdv = {4'h0, s_reg.rvlen, 8'h00, s_reg.rst,
                             5'h00, s_reg.refused, s_reg.done,
                             s_reg.busy};
      `RCRF_A_ID:     rdv = {24'h0, s_reg.id};
      `RCRF_A_DLO:    rdv = s_reg.dest[31:0];
      `RCRF_A_DHI:    rdv = s_reg.dest[63:32];
      `RCRF_A_OPTCMD: rdv = {8'h00, s_reg.opts, s_reg.cmd};
      `RCRF_A_PLO:    rdv = s_reg.prm[31:0];
      `RCRF_A_PHI:    rdv = s_reg.prm[63:32];
      `RCRF_A_PLEN:   rdv = 32'(s_reg.plen);
      `RCRF_A_RLO:    rdv = s_reg.rval[31:0];
      `RCRF_A_RHI:    rdv = s_reg.rval[63:32];
      default:        hit = 1'b0;
    endcase
  end

  // ====================================================
  // request byte generator
  assign tlen = `RCRF_LEN_MIN + 16'(s_reg.plen);
  always_comb begin
    b = rcrf_csum(s_reg.ts);
    if (s_reg.k == 16'h0000)        b = `RCRF_SOF;
    else if (s_reg.k == 16'h0001)   b = tlen[15:8];
    else if (s_reg.k == 16'h0002)   b = tlen[7:0];
    else if (s_reg.k == `RCRF_O_TYPE) b = `RCRF_T_REQ;
    else if (s_reg.k == `RCRF_O_ID) b = s_reg.id;
    else if (s_reg.k < `RCRF_O_RSVD) b = s_reg.sd[63:56];
    else if (s_reg.k == `RCRF_O_RSVD) b = 8'(`RCRF_RSVD >> 8);
    else if (s_reg.k < `RCRF_O_OPT) b = 8'(`RCRF_RSVD);
    else if (s_reg.k == `RCRF_O_OPT)
      b = s_reg.opts & `RCRF_OPT_MASK;
    else if (s_reg.k == `RCRF_O_CMD) b = s_reg.cmd[15:8];
    else if (s_reg.k < `RCRF_O_PRM) b = s_reg.cmd[7:0];
    else if (s_reg.k < `RCRF_O_PRM + 16'(s_reg.plen))
      b = s_reg.sp[8*PMAX-1 -: 8];
  end

  assign rsel = psel && !penable;
  assign wr   = psel && penable && s_reg.pready && pwrite &&
                !s_reg.pslverr;
  assign rx   = lnk.d2h_valid && s_reg.rrdy;
  assign d    = lnk.d2h_data;

  always_comb begin
    s_next         = s_reg;
    // one wait-free access cycle: answer latched in the setup cycle
    s_next.pready  = rsel;
    s_next.pslverr = rsel && !hit;
    s_next.prdata  = rsel ? rdv : 32'h0000_0000;
    s_next.rrdy    = 1'b1;
    if (wr && !s_reg.busy) begin
      unique case (paddr)
        `RCRF_A_ID:     s_next.id = pwdata[7:0];
        `RCRF_A_DLO:    s_next.dest[31:0] = pwdata;
        `RCRF_A_DHI:    s_next.dest[63:32] = pwdata;
        `RCRF_A_OPTCMD: {s_next.opts, s_next.cmd} = pwdata[23:0];
        `RCRF_A_PLO:    s_next.prm[31:0] = pwdata;
        `RCRF_A_PHI:    s_next.prm[63:32] = pwdata;
        `RCRF_A_PLEN:   s_next.plen = pwdata[PW-1:0];
        `RCRF_A_CTRL: begin
          s_next.short_a = pwdata[`RCRF_C_SHORT];
          s_next.refused = 1'b0;
          if (pwdata[`RCRF_C_GO]) begin
            s_next.done = 1'b0;
            // broadcast requests would flood the net with answers
            if (s_reg.dest == `RCRF_BCAST && !pwdata[`RCRF_C_SHORT])
              s_next.refused = 1'b1;
            else begin
              s_next.busy = 1'b1;
              s_next.txr  = 1'b1;
              s_next.k    = 16'h0000;
              s_next.ts   = 8'h00;
              s_next.sd   = pwdata[`RCRF_C_SHORT] ?
                            `RCRF_SHORT : s_reg.dest;
              s_next.sp   = (8*PMAX)'(s_reg.prm) <<
                            (8 * (PMAX - int'(s_reg.plen)));
            end
          end
        end
        default: ;
      endcase
    end
    // request transmit, one byte per accepted handshake
    if (s_reg.tv && lnk.h2d_ready) s_next.tv = 1'b0;
    if (s_reg.txr && (!s_reg.tv || lnk.h2d_ready)) begin
      s_next.tv = 1'b1;
      s_next.td = b;
      s_next.k  = s_reg.k + 16'h0001;
      if (s_reg.k >= `RCRF_O_TYPE) s_next.ts = s_reg.ts + b;
      if (s_reg.k >= `RCRF_O_DEST && s_reg.k < `RCRF_O_RSVD)
        s_next.sd = {s_reg.sd[55:0], 8'h00};
      if (s_reg.k >= `RCRF_O_PRM)
        s_next.sp = {s_reg.sp[8*PMAX-9:0], 8'h00};
      if (s_reg.k == `RCRF_O_PRM + 16'(s_reg.plen)) begin
        s_next.txr = 1'b0;
        if (s_reg.id == 8'h00) begin
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
        end
      end
    end
    // response parser
    unique case (s_reg.rs)
      st_hunt: if (rx && d == `RCRF_SOF) s_next.rs = st_len_h;
      st_len_h: if (rx) begin
        s_next.len[15:8] = d;
        s_next.rs        = st_len_l;
      end
      st_len_l: if (rx) begin
        s_next.len   = {s_reg.len[15:8], d};
        s_next.pos   = `RCRF_O_TYPE;
        s_next.sum   = 8'h00;
        s_next.rvlen = 4'h0;
        s_next.rval  = 64'h0;
        s_next.rs    = ({s_reg.len[15:8], d} < `RCRF_RSP_BASE) ?
                       st_hunt : st_body;
      end
      st_body: if (rx) begin
        s_next.sum = s_reg.sum + d;
        s_next.pos = s_reg.pos + 16'h0001;
        if (s_reg.pos == `RCRF_O_ID) s_next.idok = (d == s_reg.id);
        if (s_reg.pos == `RCRF_R_ST) s_next.rst = d;
        if (s_reg.pos >= `RCRF_R_VAL) begin
          s_next.rval  = {s_reg.rval[55:0], d};
          s_next.rvlen = s_reg.rvlen + 4'h1;
        end
        if (s_reg.pos == s_reg.len + `RCRF_O_TYPE - 16'h0001)
          s_next.rs = st_csum;
        if (s_reg.pos == `RCRF_O_TYPE && d != `RCRF_T_RSP)
          s_next.rs = st_hunt;
      end
      st_csum: if (rx) begin
        s_next.rs = st_hunt;
        if (d == rcrf_csum(s_reg.sum) && s_reg.idok &&
            s_reg.busy && !s_reg.txr) begin
          s_next.busy = 1'b0;
          s_next.done = 1'b1;
        end
      end
      default: s_next.rs = st_hunt;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) s_reg <= '0;
    else        s_reg <= s_next;
  end

  // ====================================================
  // outputs
  assign prdata        = s_reg.prdata;
  assign pready        = s_reg.pready;
  assign pslverr       = s_reg.pslverr;
  assign lnk.h2d_data  = s_reg.td;
  assign lnk.h2d_valid = s_reg.tv;
  assign lnk.d2h_ready = s_reg.rrdy;
endmodule

// ===== tb/rcrf_assertions.sv
// checker for the byte link between the two framer ends
`timescale 1ns/10ps
module rcrf_assertions (
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst_b,
  // link signals
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_valid,
  input wire logic       h2d_ready,
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_valid,
  input wire logic       d2h_ready
);
  // ====================================================
  // byte position, length and running sum, 0 = request
  logic [15:0] p [2];
  logic [15:0] n [2];
  logic [7:0]  s [2];
  logic [7:0]  b [2];
  logic [7:0]  id;
  logic [1:0]  x;
  logic [1:0]  e;
  assign b[0] = h2d_data;
  assign b[1] = d2h_data;
  assign x    = {d2h_valid & d2h_ready, h2d_valid & h2d_ready};
  // length is only known past position two, so guard on it
  assign e[0] = x[0] && p[0] > 16'h0002 && p[0] == n[0] + 16'h0003;
  assign e[1] = x[1] && p[1] > 16'h0002 && p[1] == n[1] + 16'h0003;
  // frame walkers for both directions
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      p  <= '{default: 16'h0000};
      n  <= '{default: 16'h0000};
      s  <= '{default: 8'h00};
      id <= 8'h00;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (x[k]) begin
          p[k] <= e[k] ? 16'h0000 : p[k] + 16'h0001;
          s[k] <= (p[k] < 16'h0003) ? 8'h00 : s[k] + b[k];
          if (p[k] == 16'h0001) n[k][15:8] <= b[k];
          if (p[k] == 16'h0002) n[k][7:0] <= b[k];
        end
      end
      if (x[0] && p[0] == 16'h0004) id <= h2d_data;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_req_sof: assert property (
    x[0] && p[0] == 16'h0000 |-> h2d_data == 8'h7E)
    else $error("bad request delimiter");
  a_req_type: assert property (
    x[0] && p[0] == 16'h0003 |-> h2d_data == 8'h17)
    else $error("bad request type");
  a_req_opts: assert property (
    x[0] && p[0] == 16'h000F |-> (h2d_data & 8'hEC) == 8'h00)
    else $error("unused option bit set");
  a_req_rsvd: assert property (
    x[0] && (p[0] == 16'h000D || p[0] == 16'h000E) |->
      h2d_data == (p[0][0] ? 8'hFF : 8'hFE))
    else $error("bad reserved field");
  a_req_csum: assert property (
    e[0] |-> h2d_data == 8'hFF - s[0])
    else $error("bad request checksum");
  a_rsp_type: assert property (
    x[1] && p[1] == 16'h0003 |-> d2h_data == 8'h97)
    else $error("bad response type");
  a_rsp_id: assert property (
    x[1] && p[1] == 16'h0004 |-> d2h_data == id)
    else $error("response id differs");
  a_rsp_none: assert property (
    d2h_valid |-> id != 8'h00)
    else $error("response for id zero");
  a_rsp_csum: assert property (
    e[1] |-> d2h_data == 8'hFF - s[1])
    else $error("bad response checksum");
  // main scenarios
  c_rsp: cover property (e[1]);
  c_id0: cover property (x[0] && p[0] == 16'h0004 && h2d_data == 8'h00);
  c_val: cover property (x[0] && p[0] == 16'h0012);
endmodule

// ===== tb/tb_top.sv
// self-checking bench joining the host and device framer ends
`timescale 1ns/10ps
module tb_top;
  // ====================================================
  // stimulus and observation
  logic        mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, rn_rsp_valid = 1'b0, er, pready, pslverr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        rn_req_valid, rn_write, rn_no_ack, rn_apply, rn_secure;
  logic        changes_pending, bad_frame, secure_ok = 1'b0;
  logic [63:0] rn_dest, rn_param, rn_rsp_value = 64'h0;
  logic [15:0] rn_cmd;
  logic [3:0]  rn_plen, rn_rsp_len = 4'h0;
  int          n_errors = 0, check_count = 0, cyc = 0;
  rcrf_if rcrf_if_i ();
  rcrf_host rcrf_host_i (.mclk, .rst_b, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .lnk(rcrf_if_i));
  // remote side always ready, session state set by the scenarios
  rcrf_dev rcrf_dev_i (.mclk, .rst_b, .lnk(rcrf_if_i), .rn_req_valid,
    .rn_req_ready(1'b1), .rn_write, .rn_no_ack, .rn_apply, .rn_secure,
    .rn_dest, .rn_cmd, .rn_param, .rn_plen, .rn_rsp_valid,
    .rn_rsp_status(8'h00), .rn_rsp_value, .rn_rsp_len,
    .secure_ok, .changes_pending, .bad_frame);
  rcrf_assertions rcrf_assertions_i (.mclk, .rst_b,
    .h2d_data(rcrf_if_i.h2d_data), .h2d_valid(rcrf_if_i.h2d_valid),
    .h2d_ready(rcrf_if_i.h2d_ready), .d2h_data(rcrf_if_i.d2h_data),
    .d2h_valid(rcrf_if_i.d2h_valid), .d2h_ready(rcrf_if_i.d2h_ready));
  // clock
  initial forever #5 mclk = ~mclk;
  // a hang ends the run as a mismatch
  always @(posedge mclk) begin
    cyc++;
    if (rst_b) chk(bad_frame, 1'b0);
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one APB transfer, waits for pready however long it takes
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll status until the host end is no longer busy
  task automatic idle();
    do apb(1'b0, 8'h04, 32'h0); while (rd[0] !== 1'b0);
  endtask
  // remote node: check the request, then answer with a value
  task automatic remote(input logic [86:0] ex, input logic [63:0] ep,
                        input logic [63:0] v, input logic [3:0] l);
    while (rn_req_valid !== 1'b1) @(posedge mclk);
    chk({rn_write, rn_no_ack, rn_apply, rn_plen, rn_cmd, rn_dest},
        ex);
    chk(rn_param, ep);
    @(posedge mclk);
    rn_rsp_valid <= 1'b1;
    rn_rsp_value <= v;
    rn_rsp_len   <= l;
    @(posedge mclk);
    rn_rsp_valid <= 1'b0;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    apb(1'b1, 8'h0C, 32'h1234_5678);
    apb(1'b1, 8'h10, 32'h0013_A200);
    // write with id zero, short address, change left pending
    apb(1'b1, 8'h14, 32'h0000_4944);
    apb(1'b1, 8'h18, 32'h0000_0451);
    apb(1'b1, 8'h20, 32'h2);
    apb(1'b1, 8'h00, 32'h3);
    remote({3'b100, 4'h2, 16'h4944, 64'hFFFF_FFFF_FFFF_FFFF},
           64'h0451, 64'h0, 4'h0);
    idle();
    chk(changes_pending, 1'b1);
    // read with id five, acks off and apply on
    apb(1'b1, 8'h08, 32'h5);
    apb(1'b1, 8'h14, 32'h0003_5450);
    apb(1'b1, 8'h20, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    remote({3'b011, 4'h0, 16'h5450, 64'h0013_A200_1234_5678},
           64'h0, 64'h1234, 4'h2);
    idle();
    chk(rd & 32'h0F00_FF03, 32'h0200_0002);
    apb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h1234);
    chk(changes_pending, 1'b0);
    // encrypted request without a session is answered locally
    apb(1'b1, 8'h08, 32'h9);
    apb(1'b1, 8'h14, 32'h0010_5450);
    apb(1'b1, 8'h00, 32'h1);
    idle();
    chk(rd & 32'h0000_FF03, 32'h0000_E002);
    chk(rn_secure, 1'b1);
    // with a session the encrypted request goes out
    secure_ok <= 1'b1;
    apb(1'b1, 8'h00, 32'h1);
    remote({3'b000, 4'h0, 16'h5450, 64'h0013_A200_1234_5678},
           64'h0, 64'h7, 4'h1);
    idle();
    chk(rd & 32'h0F00_FF03, 32'h0100_0002);
    // broadcast destination without short addressing is refused
    apb(1'b1, 8'h0C, 32'h0000_FFFF);
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h7, 32'h4);
    print_verdict();
  end
endmodule
